/* File: flash_lock_defs.svh */
`ifndef FLASH_LOCK_DEFS_SVH
`define FLASH_LOCK_DEFS_SVH

`define STAT_DATA_POLL_BIT   7
`define STAT_TOGGLE_BIT      6
`define STAT_ERROR_BIT       5
`define STAT_ERASE_TMR_BIT   3
`define STAT_TOGGLE2_BIT     2

`define LOCK_BLOCK_LSB       0
`define LOCK_BLOCK_MSB       6
`define LOCK_CODE_BIT        15
`define LOCK_WORD_RESET      16'hffff
`define LOCK_WORD_USED_MASK  16'h807f

`define CODE_LOCK_READ_VALUE 16'h009b
`define ERASED_WORD          16'hffff

`endif

/* File: flash_lock_pkg.sv */
package flash_lock_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE_WAIT,
    ST_ERASE,
    ST_SUSPEND,
    ST_CONFIRM,
    ST_FINAL,
    ST_FAIL
  } engine_state_t;

endpackage

/* File: nv_lock_store.sv */
`timescale 1ns/10ps
`include "flash_lock_defs.svh"

// Non-volatile copy of the lock word. It is cleared only by power-on, never
// by the ordinary device reset, so it models storage that survives a device reset but not power-on.
module nv_lock_store
(
  input  wire logic        clk_sys_i,
  input  wire logic        pwr_on_nrst_i,
  input  wire logic        lock_set_cmd_i,
  input  wire logic [15:0] lock_set_data_i,
  output logic      [15:0] nv_word_o
);

  logic [15:0] nv_word_ff;

  // Bits can only fall from one to zero; a one written over a zero is ignored.
  always_ff @(posedge clk_sys_i or negedge pwr_on_nrst_i)
  begin
    if (!pwr_on_nrst_i)
      nv_word_ff <= `LOCK_WORD_RESET;
    else if (lock_set_cmd_i)
      nv_word_ff <= nv_word_ff & (lock_set_data_i | ~`LOCK_WORD_USED_MASK);
  end

  assign nv_word_o = nv_word_ff;

endmodule

/* File: flash_status_lock.sv */
`timescale 1ns/10ps
`include "flash_lock_defs.svh"

// What this block does
// - Toggle bit inverts on every status read while programming or erasing.
// - After completion, one status read repeats the toggle bit; the read after it gives last programmed bit, or one after erase.
// - Reading a suspended block forces the toggle bit to one.
// - Erase suspend and erase resume commands each flip the toggle bit.
// - While programming, reading the programmed address returns the status word.
// - While erasing, reading any address of the erased block returns status.
// - Lock word lives in storage that survives device reset; power-on reset sets it back to ffff.
// - Lock word is read only by lock-status read, written only by lock-set.
// - Lock word holds block locks in bits 0 to 6, code lock in bit 15.
// - A zero block lock bit rejects program and erase unless temporarily unlocked.
// - Block lock bits default to one and can only be cleared for good.
// - Code lock zero makes reads not fetched from flash return 009B.
// - Code lock one allows reads from external memory or internal RAM code.
// - Code lock defaults to one, clears permanently, overridden by temporary unlock.
// - A failed operation sets the error bit until read/reset recovers.
// - Erase timer bit reads zero during confirm time-out, one once erasing.
// - In suspend, other blocks give array data; suspended block toggles second bit.
// - Data polling bit reads zero during erase and one after it completes.
module flash_status_lock
#(
  parameter int ADDR_W  = 17,
  parameter int BLOCK_W = 3
)
(
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic              pwr_on_nrst_i,
  input  wire logic              rd_req_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  input  wire logic              rd_fetch_flash_i,
  input  wire logic [15:0]       array_data_i,
  input  wire logic              prog_req_i,
  input  wire logic [ADDR_W-1:0] prog_addr_i,
  input  wire logic [15:0]       prog_data_i,
  input  wire logic              erase_req_i,
  input  wire logic [ADDR_W-1:0] erase_addr_i,
  input  wire logic              erase_timer_done_i,
  input  wire logic              eng_done_i,
  input  wire logic              eng_fail_i,
  input  wire logic              erase_suspend_cmd_i,
  input  wire logic              erase_resume_cmd_i,
  input  wire logic              read_reset_cmd_i,
  input  wire logic              lock_status_read_cmd_i,
  input  wire logic              lock_set_cmd_i,
  input  wire logic [15:0]       lock_set_data_i,
  input  wire logic              temp_block_unlock_cmd_i,
  input  wire logic              temp_code_unlock_cmd_i,
  output logic      [15:0]       rd_data_o,
  output logic                   rd_valid_o,
  output logic                   op_reject_o,
  output logic                   busy_o
);

  flash_lock_pkg::engine_state_t state_ff;

  logic [15:0]        nv_word;
  logic [15:0]        lock_word_ff;
  logic               lock_loaded_ff;
  logic               lock_read_mode_ff;
  logic               temp_block_ff;
  logic               temp_code_ff;
  logic [ADDR_W-1:0]  op_addr_ff;
  logic [1:0]         prog_bits_ff;
  logic               last_erase_ff;
  logic               toggle_ff;
  logic               toggle2_ff;
  logic [15:0]        rd_data_ff;
  logic               rd_valid_ff;
  logic               reject_ff;
  logic               busy_ff;

  logic               status_hit;
  logic               susp_hit;
  logic               prog_ok;
  logic               erase_ok;
  logic [15:0]        status_word;

  function automatic logic [BLOCK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
    block_of = a[ADDR_W-1 -: BLOCK_W];
  endfunction

  // Block 7 has no lock bit and is never locked.
  function automatic logic block_locked(input logic [ADDR_W-1:0] a,
                                        input logic [15:0]       w);
    logic [BLOCK_W-1:0] b;
    b = block_of(a);
    block_locked = (b <= BLOCK_W'(`LOCK_BLOCK_MSB)) && !w[`LOCK_BLOCK_LSB + b];
  endfunction

  nv_lock_store u_nv_lock_store
  (
    .clk_sys_i       (clk_sys_i),
    .pwr_on_nrst_i   (pwr_on_nrst_i),
    .lock_set_cmd_i  (lock_set_cmd_i),
    .lock_set_data_i (lock_set_data_i),
    .nv_word_o       (nv_word)
  );

  // The working copy is taken from storage once after each reset release, so a
  // lock-set only shows up after the next reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lock_word_ff   <= `LOCK_WORD_RESET;
      lock_loaded_ff <= 1'b0;
    end
    else if (!lock_loaded_ff)
    begin
      lock_word_ff   <= nv_word & `LOCK_WORD_USED_MASK | ~`LOCK_WORD_USED_MASK;
      lock_loaded_ff <= 1'b1;
    end
  end

  // Lock-status mode lasts until read/reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lock_read_mode_ff <= 1'b0;
    else if (read_reset_cmd_i)
      lock_read_mode_ff <= 1'b0;
    else if (lock_status_read_cmd_i)
      lock_read_mode_ff <= 1'b1;
  end

  // Temporary unlocks last until the next reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      temp_block_ff <= 1'b0;
      temp_code_ff  <= 1'b0;
    end
    else
    begin
      if (temp_block_unlock_cmd_i)
        temp_block_ff <= 1'b1;
      if (temp_code_unlock_cmd_i)
        temp_code_ff <= 1'b1;
    end
  end

  assign prog_ok  = temp_block_ff || !block_locked(prog_addr_i, lock_word_ff);
  assign erase_ok = temp_block_ff || !block_locked(erase_addr_i, lock_word_ff);

  assign status_hit = ((state_ff == flash_lock_pkg::ST_PROG) && (rd_addr_i == op_addr_ff))
                   || ((state_ff == flash_lock_pkg::ST_ERASE_WAIT
                     || state_ff == flash_lock_pkg::ST_ERASE
                     || state_ff == flash_lock_pkg::ST_FAIL
                     || state_ff == flash_lock_pkg::ST_CONFIRM)
                     && (last_erase_ff ? block_of(rd_addr_i) == block_of(op_addr_ff)
                                       : rd_addr_i == op_addr_ff));
  assign susp_hit   = (state_ff == flash_lock_pkg::ST_SUSPEND)
                   && (block_of(rd_addr_i) == block_of(op_addr_ff));

  always_comb
  begin
    status_word = 16'h0000;
    status_word[`STAT_DATA_POLL_BIT] = last_erase_ff
                                       ? (state_ff == flash_lock_pkg::ST_CONFIRM)
                                       : (state_ff == flash_lock_pkg::ST_CONFIRM) == prog_bits_ff[1];
    status_word[`STAT_TOGGLE_BIT]    = (state_ff == flash_lock_pkg::ST_CONFIRM
                                       || state_ff == flash_lock_pkg::ST_FAIL)
                                       ? toggle_ff : ~toggle_ff;
    status_word[`STAT_ERROR_BIT]     = (state_ff == flash_lock_pkg::ST_FAIL);
    status_word[`STAT_ERASE_TMR_BIT] = (state_ff != flash_lock_pkg::ST_ERASE_WAIT);
    status_word[`STAT_TOGGLE2_BIT]   = ~toggle2_ff;
  end

  // Operation sequencing. Only one operation is tracked at a time; requests that
  // arrive while busy are ignored, since the command layer already refuses them.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff      <= flash_lock_pkg::ST_IDLE;
      op_addr_ff    <= '0;
      prog_bits_ff  <= 2'b11;
      last_erase_ff <= 1'b0;
    end
    else if (read_reset_cmd_i)
      state_ff <= flash_lock_pkg::ST_IDLE;
    else
    begin
      unique case (state_ff)
        flash_lock_pkg::ST_IDLE, flash_lock_pkg::ST_FINAL:
        begin
          if (prog_req_i && prog_ok)
          begin
            state_ff      <= flash_lock_pkg::ST_PROG;
            op_addr_ff    <= prog_addr_i;
            prog_bits_ff  <= {prog_data_i[`STAT_DATA_POLL_BIT], prog_data_i[`STAT_TOGGLE_BIT]};
            last_erase_ff <= 1'b0;
          end
          else if (erase_req_i && erase_ok)
          begin
            state_ff      <= flash_lock_pkg::ST_ERASE_WAIT;
            op_addr_ff    <= erase_addr_i;
            last_erase_ff <= 1'b1;
          end
          else if (state_ff == flash_lock_pkg::ST_FINAL && rd_req_i)
            state_ff <= flash_lock_pkg::ST_IDLE;
        end
        flash_lock_pkg::ST_PROG, flash_lock_pkg::ST_ERASE:
        begin
          if (eng_fail_i)
            state_ff <= flash_lock_pkg::ST_FAIL;
          else if (eng_done_i)
            state_ff <= flash_lock_pkg::ST_CONFIRM;
          else if (erase_suspend_cmd_i && state_ff == flash_lock_pkg::ST_ERASE)
            state_ff <= flash_lock_pkg::ST_SUSPEND;
        end
        flash_lock_pkg::ST_ERASE_WAIT:
        begin
          if (erase_suspend_cmd_i)
            state_ff <= flash_lock_pkg::ST_SUSPEND;
          else if (erase_timer_done_i)
            state_ff <= flash_lock_pkg::ST_ERASE;
        end
        flash_lock_pkg::ST_SUSPEND:
        begin
          if (erase_resume_cmd_i)
            state_ff <= flash_lock_pkg::ST_ERASE;
        end
        flash_lock_pkg::ST_CONFIRM:
        begin
          if (rd_req_i && status_hit)
            state_ff <= flash_lock_pkg::ST_FINAL;
        end
        flash_lock_pkg::ST_FAIL:
        begin
          state_ff <= flash_lock_pkg::ST_FAIL;
        end
      endcase
    end
  end

  // Toggle bits. A status read flips both while the operation runs, and flips the second one also on a
  // suspended-block read in suspend; suspend and resume flip the main one as well.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      toggle_ff  <= 1'b0;
      toggle2_ff <= 1'b0;
    end
    else
    begin
      if (erase_suspend_cmd_i && (state_ff == flash_lock_pkg::ST_ERASE
          || state_ff == flash_lock_pkg::ST_ERASE_WAIT))
        toggle_ff <= ~toggle_ff;
      else if (erase_resume_cmd_i && state_ff == flash_lock_pkg::ST_SUSPEND)
        toggle_ff <= ~toggle_ff;
      else if (rd_req_i && status_hit && state_ff != flash_lock_pkg::ST_CONFIRM
               && state_ff != flash_lock_pkg::ST_FAIL)
        toggle_ff <= ~toggle_ff;
      if (rd_req_i && (status_hit || susp_hit) && state_ff != flash_lock_pkg::ST_CONFIRM
          && state_ff != flash_lock_pkg::ST_FAIL)
        toggle2_ff <= ~toggle2_ff;
    end
  end

  // Read answer, one cycle after the request.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_data_ff  <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_req_i;
      if (rd_req_i)
      begin
        if (lock_read_mode_ff)
          rd_data_ff <= lock_word_ff;
        else if (!rd_fetch_flash_i && !lock_word_ff[`LOCK_CODE_BIT] && !temp_code_ff)
          rd_data_ff <= `CODE_LOCK_READ_VALUE;
        else if (susp_hit)
        begin
          rd_data_ff <= status_word;
          rd_data_ff[`STAT_TOGGLE_BIT]    <= 1'b1;
          rd_data_ff[`STAT_DATA_POLL_BIT] <= 1'b1;
        end
        else if (status_hit)
          rd_data_ff <= status_word;
        else if (state_ff == flash_lock_pkg::ST_FINAL && rd_addr_i == op_addr_ff)
        begin
          rd_data_ff <= last_erase_ff ? `ERASED_WORD : array_data_i;
          rd_data_ff[`STAT_TOGGLE_BIT] <= last_erase_ff | prog_bits_ff[0];
        end
        else if (state_ff == flash_lock_pkg::ST_FINAL && last_erase_ff
                 && block_of(rd_addr_i) == block_of(op_addr_ff))
          rd_data_ff <= `ERASED_WORD;
        else
          rd_data_ff <= array_data_i;
      end
    end
  end

  // Reject pulse for a program or erase aimed at a locked block.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reject_ff <= 1'b0;
      busy_ff   <= 1'b0;
    end
    else
    begin
      reject_ff <= (prog_req_i && !prog_ok) || (erase_req_i && !prog_req_i && !erase_ok);
      busy_ff   <= (state_ff == flash_lock_pkg::ST_PROG) || (state_ff == flash_lock_pkg::ST_ERASE)
                || (state_ff == flash_lock_pkg::ST_ERASE_WAIT);
    end
  end

  assign rd_data_o   = rd_data_ff;
  assign rd_valid_o  = rd_valid_ff;
  assign op_reject_o = reject_ff;
  assign busy_o      = busy_ff;

endmodule

/* File: flash_status_lock_monitor.sv */
`timescale 1ns/10ps
module flash_status_lock_monitor
(
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        rd_req_i,
  input wire logic        prog_req_i,
  input wire logic        erase_req_i,
  input wire logic        eng_done_i,
  input wire logic        eng_fail_i,
  input wire logic        erase_suspend_cmd_i,
  input wire logic        erase_resume_cmd_i,
  input wire logic        read_reset_cmd_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic        op_reject_o,
  input wire logic        busy_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_op_req;
    prog_req_i || erase_req_i;
  endsequence

  // A refused request must not start the engine two cycles later.
  sequence s_refused;
    s_op_req ##1 op_reject_o;
  endsequence

  a_valid_follows_req:
    assert property (rd_req_i |=> rd_valid_o) else $error("read answer missing");
  a_valid_needs_req:
    assert property (!rd_req_i |=> !rd_valid_o) else $error("read answer without read");
  a_data_holds:
    assert property (!rd_req_i |=> $stable(rd_data_o)) else $error("read data moved");
  a_reject_has_cause:
    assert property (op_reject_o |-> $past(prog_req_i || erase_req_i))
      else $error("refusal without request");
  a_refused_stays_idle:
    assert property (s_refused |=> !$rose(busy_o)) else $error("refused request started");
  a_busy_has_cause:
    assert property ($rose(busy_o) |-> $past(prog_req_i || erase_req_i || erase_resume_cmd_i, 2))
      else $error("busy rose without request");
  a_busy_stop_cause:
    assert property ($fell(busy_o) |->
      $past(eng_done_i || eng_fail_i || read_reset_cmd_i || erase_suspend_cmd_i, 2))
      else $error("busy fell without cause");
  a_reset_quiet:
    assert property (disable iff (1'b0) !nrst_i |-> !rd_valid_o && !op_reject_o && !busy_o)
      else $error("outputs active in reset");
endmodule

bind flash_status_lock flash_status_lock_monitor u_flash_status_lock_monitor
(
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rd_req_i(rd_req_i), .prog_req_i(prog_req_i),
  .erase_req_i(erase_req_i), .eng_done_i(eng_done_i), .eng_fail_i(eng_fail_i),
  .erase_suspend_cmd_i(erase_suspend_cmd_i), .erase_resume_cmd_i(erase_resume_cmd_i),
  .read_reset_cmd_i(read_reset_cmd_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .op_reject_o(op_reject_o), .busy_o(busy_o)
);

/* File: flash_engine_model.sv */
`timescale 1ns/10ps
// Plays the erase/write engine. The bench picks the outcome and the delay,
// so the engine can answer promptly or slowly.
module flash_engine_model
(
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       go_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [7:0] dly_i,
  output logic      [2:0] pulse_o
);
  logic [8:0] cnt_ff;
  logic [1:0] sel_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
    if (!nrst_i)
      cnt_ff <= 9'h000;
    else if (go_i)
      cnt_ff <= {1'b0, dly_i} + 9'h001;
    else if (cnt_ff != 9'h000)
      cnt_ff <= cnt_ff - 9'h001;

  always_ff @(posedge clk_sys_i)
    if (go_i)
      sel_ff <= sel_i;

  // Bit 0 is done, bit 1 is failure, bit 2 is timer expiry; each lasts one cycle.
  assign pulse_o = (cnt_ff == 9'h001) ? (3'h1 << sel_ff) : 3'h0;
endmodule

/* File: flash_status_lock_bench.sv */
`timescale 1ns/10ps
module flash_status_lock_bench;
  localparam logic [15:0] PDATA = 16'h5a3c;
  localparam logic [16:0] PADDR = 17'h00010;
  localparam logic [16:0] EADDR = 17'h08004;
  logic        clk = 1'b0, nrst = 1'b1, pwr = 1'b1, rd_req = 1'b0, fetch = 1'b1;
  logic        pr = 1'b0, er = 1'b0, go = 1'b0, valid, rej, busy;
  logic [1:0]  sel = 2'h0;
  logic [2:0]  eng;
  logic [6:0]  cmd = 7'h00;
  logic [7:0]  dly = 8'h00;
  logic [15:0] arr = 16'h0000, lock_data = 16'hffff, rd_data;
  logic [16:0] rd_addr = 17'h00000, op_addr = 17'h00000;
  int          checked = 0, mismatches = 0, cycles = 0;

  flash_status_lock u_flash_status_lock
  (
    .clk_sys_i(clk), .nrst_i(nrst), .pwr_on_nrst_i(pwr), .rd_req_i(rd_req),
    .rd_addr_i(rd_addr), .rd_fetch_flash_i(fetch), .array_data_i(arr),
    .prog_req_i(pr), .prog_addr_i(op_addr), .prog_data_i(PDATA), .erase_req_i(er),
    .erase_addr_i(op_addr), .erase_timer_done_i(eng[2]), .eng_done_i(eng[0]),
    .eng_fail_i(eng[1]), .erase_suspend_cmd_i(cmd[0]), .erase_resume_cmd_i(cmd[1]),
    .read_reset_cmd_i(cmd[2]), .lock_status_read_cmd_i(cmd[3]),
    .lock_set_cmd_i(cmd[4]), .lock_set_data_i(lock_data),
    .temp_block_unlock_cmd_i(cmd[5]), .temp_code_unlock_cmd_i(cmd[6]),
    .rd_data_o(rd_data), .rd_valid_o(valid), .op_reject_o(rej), .busy_o(busy)
  );

  flash_engine_model u_flash_engine_model
  (
    .clk_sys_i(clk), .nrst_i(nrst), .go_i(go), .sel_i(sel), .dly_i(dly), .pulse_o(eng)
  );

  initial
    forever #2 clk = ~clk;

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic [16:0] a, input logic f, input logic [15:0] d,
                    output logic [15:0] q);
    rd_addr = a;
    fetch = f;
    arr = d;
    rd_req = 1'b1;
    tick();
    rd_req = 1'b0;
    chk("read valid", valid, 1'b1);
    q = rd_data;
    // One idle edge keeps back-to-back reads from re-raising the request in one step.
    tick();
  endtask

  task automatic rdc(input string nm, input logic [16:0] a, input logic f,
                     input logic [15:0] d, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
    rd(a, f, d, q);
    chk(nm, q & m, e);
  endtask

  task automatic op(input logic e, input logic [16:0] a, output logic rj);
    op_addr = a;
    pr = ~e;
    er = e;
    tick();
    pr = 1'b0;
    er = 1'b0;
    rj = rej;
    tick();
  endtask

  task automatic pulse(input int b);
    cmd[b] = 1'b1;
    tick();
    cmd = 7'h00;
    tick();
  endtask

  task automatic run_eng(input logic [1:0] s, input logic [7:0] n);
    sel = s;
    dly = n;
    go = 1'b1;
    tick();
    go = 1'b0;
  endtask

  // Bounded so that a busy flag that never drops cannot hang the run.
  task automatic wait_idle();
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      tick();
    chk("busy low", busy, 1'b0);
  endtask

  task automatic dev_rst();
    nrst = 1'b0;
    tick();
    nrst = 1'b1;
    tick();
    tick();
  endtask

  task automatic t_prog();
    logic [15:0] r1, r2;
    logic        rj;
    op(1'b0, PADDR, rj);
    chk("prog busy", busy, 1'b1);
    rd(PADDR, 1'b1, 16'hffff, r1);
    rd(PADDR, 1'b1, 16'hffff, r2);
    chk("poll bit", {15'h0, r1[7]}, {15'h0, ~PDATA[7]});
    chk("toggle flip", {15'h0, r2[6]}, {15'h0, ~r1[6]});
    rdc("other word", PADDR + 17'h1, 1'b1, 16'h1111, 16'hffff, 16'h1111);
    run_eng(2'h0, 8'h04);
    wait_idle();
    rdc("toggle same", PADDR, 1'b1, 16'hffff, 16'h0040, {9'h0, r2[6], 6'h0});
    rdc("last bit", PADDR, 1'b1, 16'hffff, 16'hffff, {9'h1ff, PDATA[6], 6'h3f});
    $display("program test done");
  endtask

  task automatic t_erase();
    logic [15:0] r1;
    logic        rj;
    op(1'b1, EADDR, rj);
    rdc("timer poll", EADDR + 17'h3, 1'b1, 16'h0000, 16'h0088, 16'h0000);
    run_eng(2'h2, 8'h00);
    repeat (3) tick();
    rdc("timer high", EADDR, 1'b1, 16'h0000, 16'h0008, 16'h0008);
    pulse(0);
    rd(EADDR, 1'b1, 16'h0000, r1);
    chk("suspended toggle", r1[6], 1'b1);
    rdc("second toggle", EADDR, 1'b1, 16'h0000, 16'h0044,
        {9'h0, 1'b1, 3'h0, ~r1[2], 2'h0});
    rdc("other block", 17'h00020, 1'b1, 16'h2222, 16'hffff, 16'h2222);
    pulse(1);
    run_eng(2'h0, 8'h03);
    wait_idle();
    rdc("erase poll", EADDR, 1'b1, 16'h0000, 16'h0080, 16'h0080);
    rdc("erased word", EADDR, 1'b1, 16'h0000, 16'hffff, 16'hffff);
    $display("erase test done");
  endtask

  task automatic t_fail();
    logic rj;
    op(1'b0, PADDR, rj);
    run_eng(2'h1, 8'h02);
    wait_idle();
    rdc("error bit", PADDR, 1'b1, 16'h3333, 16'h0020, 16'h0020);
    pulse(2);
    rdc("recovered", PADDR, 1'b0, 16'h3333, 16'hffff, 16'h3333);
    $display("failure test done");
  endtask

  task automatic t_lock();
    logic rj;
    lock_data = 16'hfffe;
    pulse(4);
    pulse(3);
    rdc("old lock", 17'h00001, 1'b1, 16'h0000, 16'hffff, 16'hffff);
    pulse(2);
    dev_rst();
    pulse(3);
    rdc("new lock", 17'h00003, 1'b1, 16'h0000, 16'hffff, 16'hfffe);
    pulse(2);
    op(1'b1, 17'h00008, rj);
    chk("erase refused", rj, 1'b1);
    op(1'b0, 17'h00008, rj);
    chk("prog refused", {rj, busy}, 2'h2);
    pulse(5);
    op(1'b0, 17'h00008, rj);
    chk("unlocked prog", {rj, busy}, 2'h1);
    run_eng(2'h0, 8'h01);
    wait_idle();
    $display("lock test done");
  endtask

  task automatic t_code();
    lock_data = 16'h7fff;
    pulse(4);
    lock_data = 16'hffff;
    pulse(4);
    dev_rst();
    rdc("code locked", PADDR, 1'b0, 16'h4444, 16'hffff, 16'h009b);
    rdc("flash fetch", PADDR, 1'b1, 16'h4444, 16'hffff, 16'h4444);
    pulse(3);
    rdc("kept cleared", PADDR, 1'b1, 16'h0000, 16'hffff, 16'h7ffe);
    pulse(2);
    pulse(6);
    rdc("code unlocked", PADDR, 1'b0, 16'h4444, 16'hffff, 16'h4444);
    $display("code lock test done");
  endtask

  initial
  begin
    // Drop both resets after time zero so the asynchronous reset edge is seen.
    #1;
    nrst = 1'b0;
    pwr = 1'b0;
    repeat (4) tick();
    nrst = 1'b1;
    pwr = 1'b1;
    tick();
    tick();
    t_prog();
    t_erase();
    t_fail();
    t_lock();
    t_code();
    wrap_up();
  end
endmodule
